/* verilog/timer_output_gate_ch34.sv */
/*
  Output gate for the six waveform pins of timer channels 3 and 4, with
  the master enable and level/trigger control registers on APB.
  Assumes the channel logic, port logic, capture event, standby and mode
  select all run on MCLK_I; pads resolve level and enable outside.
*/
`timescale 1ns/1ps
module timer_output_gate_ch34 (
  input wire logic MCLK_I, // system clock, 25 MHz
  input wire logic RST_B_I, // asynchronous reset, active low
  input wire logic PSEL_I, // APB select
  input wire logic PENABLE_I, // APB access phase
  input wire logic PWRITE_I, // APB write
  input wire logic [11:0] PADDR_I, // APB byte address
  input wire logic [31:0] PWDATA_I, // APB write data
  output logic [31:0] PRDATA_O, // APB read data
  output logic PREADY_O, // APB ready
  output logic PSLVERR_O, // APB error on unmapped address
  input wire logic STANDBY_I, // standby entry, reloads both registers
  input wire logic CAPTURE_A_CH1_I, // channel 1 input capture A event pulse
  input wire logic COMBINATION_MODE_HI_I, // combination mode select high bit
  input wire logic COMBINATION_MODE_LO_I, // combination mode select low bit
  input wire logic [5:0] TIMER_LEVEL_I, // channel waveform levels per pin
  input wire logic [5:0] TIMER_OE_I, // channel settings make pin an output
  input wire logic [5:0] GPIO_LEVEL_I, // port logic levels per pin
  input wire logic [5:0] GPIO_OE_I, // port logic drive enables per pin
  output logic [5:0] PIN_LEVEL_O, // pad output levels
  output logic [5:0] PIN_OE_O // pad output enables, high while driving
);

  typedef struct packed {
    logic [5:0] enable;
    logic ext_trigger_disable;
    logic level_select_group_a;
    logic level_select_group_b;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] pin_level;
    logic [5:0] pin_oe;
  } gate_state_t;

  gate_state_t state;
  gate_state_t next_state;

  logic setup;
  logic hit_enable;
  logic hit_control;
  logic unmapped;
  logic access_done;
  logic combo_mode;
  logic trigger;
  logic [5:0] invert;
  logic [5:0] mux_level;
  logic [5:0] mux_oe;
  logic [7:0] enable_read;
  logic [7:0] control_read;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and register views

  apb_word_decode u_decode (
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .setup_o(setup),
    .hit_enable_o(hit_enable),
    .hit_control_o(hit_control),
    .unmapped_o(unmapped)
  );

  assign access_done = PSEL_I && PENABLE_I && state.pready;
  assign combo_mode = ({COMBINATION_MODE_HI_I, COMBINATION_MODE_LO_I}
                       == out_gate_pkg::COMBO_COMPLEMENTARY)
                   || ({COMBINATION_MODE_HI_I, COMBINATION_MODE_LO_I}
                       == out_gate_pkg::COMBO_RESET_SYNC);
  assign trigger = CAPTURE_A_CH1_I && combo_mode && !state.ext_trigger_disable;

  // reserved bits are forced to one on read, never stored
  assign enable_read = out_gate_pkg::MASTER_ENABLE_RSVD | {2'h0, state.enable};
  assign control_read = out_gate_pkg::LEVEL_TRIGGER_RSVD
    | {3'h0, state.ext_trigger_disable, 2'h0,
       state.level_select_group_a, state.level_select_group_b};

  // inversion is only honoured in the combination modes
  assign invert = combo_mode ?
    (({6{!state.level_select_group_a}} & out_gate_pkg::GROUP_A_PINS)
    | ({6{!state.level_select_group_b}} & out_gate_pkg::GROUP_B_PINS)) : 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin selection

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pin
      pin_output_mux u_mux (
        .enable_i(state.enable[g]),
        .invert_i(invert[g]),
        .timer_level_i(TIMER_LEVEL_I[g]),
        .timer_oe_i(TIMER_OE_I[g]),
        .gpio_level_i(GPIO_LEVEL_I[g]),
        .gpio_oe_i(GPIO_OE_I[g]),
        .level_o(mux_level[g]),
        .oe_o(mux_oe[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_state = state;
    next_state.pin_level = mux_level;
    next_state.pin_oe = mux_oe;
    // zero wait states: ready rises for the access phase after each setup
    next_state.pready = setup;
    next_state.pslverr = setup && unmapped;
    if (setup) begin
      if (PWRITE_I || unmapped) begin
        next_state.prdata = 32'h0000_0000;
      end else if (hit_enable) begin
        next_state.prdata = {24'h00_0000, enable_read};
      end else begin
        next_state.prdata = {24'h00_0000, control_read};
      end
    end else if (access_done) begin
      next_state.prdata = 32'h0000_0000;
    end
    if (access_done && PWRITE_I) begin
      if (hit_enable) begin
        next_state.enable = PWDATA_I[5:0];
      end else if (hit_control) begin
        next_state.ext_trigger_disable = PWDATA_I[out_gate_pkg::BIT_EXT_TRIGGER_DISABLE];
        next_state.level_select_group_a = PWDATA_I[out_gate_pkg::BIT_LEVEL_GROUP_A];
        next_state.level_select_group_b = PWDATA_I[out_gate_pkg::BIT_LEVEL_GROUP_B];
      end
    end
    // the trigger beats a simultaneous software write so no event is lost
    if (trigger) begin
      next_state.enable = out_gate_pkg::ENABLE_NONE;
    end
    if (STANDBY_I) begin
      next_state.enable = out_gate_pkg::MASTER_ENABLE_RESET[5:0];
      next_state.ext_trigger_disable =
        out_gate_pkg::LEVEL_TRIGGER_RESET[out_gate_pkg::BIT_EXT_TRIGGER_DISABLE];
      next_state.level_select_group_a =
        out_gate_pkg::LEVEL_TRIGGER_RESET[out_gate_pkg::BIT_LEVEL_GROUP_A];
      next_state.level_select_group_b =
        out_gate_pkg::LEVEL_TRIGGER_RESET[out_gate_pkg::BIT_LEVEL_GROUP_B];
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state.enable <= out_gate_pkg::MASTER_ENABLE_RESET[5:0];
      state.ext_trigger_disable <= 1'b1;
      state.level_select_group_a <= 1'b1;
      state.level_select_group_b <= 1'b1;
      state.prdata <= 32'h0000_0000;
      state.pready <= 1'b0;
      state.pslverr <= 1'b0;
      state.pin_level <= 6'h00;
      state.pin_oe <= 6'h00;
    end else begin
      state <= next_state;
    end
  end

  assign PRDATA_O = state.prdata;
  assign PREADY_O = state.pready;
  assign PSLVERR_O = state.pslverr;
  assign PIN_LEVEL_O = state.pin_level;
  assign PIN_OE_O = state.pin_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);

  sequence enable_read_access;
    PSEL_I && !PENABLE_I && !PWRITE_I && hit_enable ##1 PSEL_I && PENABLE_I;
  endsequence

  sequence control_read_access;
    PSEL_I && !PENABLE_I && !PWRITE_I && hit_control ##1 PSEL_I && PENABLE_I;
  endsequence

  standby_enable_a: assert property (STANDBY_I |=> state.enable == 6'h3f)
    else $error("standby did not set all master enables");

  standby_control_a: assert property (STANDBY_I |=> control_read == 8'hff)
    else $error("standby did not set control register to all ones");

  enable_rsvd_a: assert property (enable_read_access |-> PREADY_O && PRDATA_O[7:6] == 2'h3)
    else $error("master enable reserved bits did not read as one");

  control_rsvd_a: assert property (control_read_access
    |-> PREADY_O && PRDATA_O[7:5] == 3'h7 && PRDATA_O[3:2] == 2'h3)
    else $error("control reserved bits did not read as one");

  trigger_clear_a: assert property (
    CAPTURE_A_CH1_I && combo_mode && !state.ext_trigger_disable && !STANDBY_I
    |=> state.enable == 6'h00 ##1 PIN_OE_O == $past(GPIO_OE_I))
    else $error("external trigger did not disable all outputs");

  // a capture in the same cycle as a master enable write must still disable
  trigger_wins_a: assert property (
    trigger && access_done && PWRITE_I && hit_enable && !STANDBY_I
    |=> state.enable == 6'h00)
    else $error("software write overrode the external trigger");

  trigger_off_a: assert property (
    CAPTURE_A_CH1_I && (state.ext_trigger_disable || !combo_mode)
    && !STANDBY_I && !(access_done && PWRITE_I) |=> $stable(state.enable))
    else $error("ignored trigger changed master enables");

  normal_level_a: assert property (!combo_mode && state.enable[0]
    |=> PIN_LEVEL_O[0] == $past(TIMER_LEVEL_I[0]))
    else $error("level inverted outside combination modes");

  invert_group_a_a: assert property (combo_mode && state.enable[1]
    && !state.level_select_group_a |=> PIN_LEVEL_O[1] == !$past(TIMER_LEVEL_I[1]))
    else $error("group A level not inverted");

  invert_group_b_a: assert property (combo_mode && state.enable[4]
    && !state.level_select_group_b |=> PIN_LEVEL_O[4] == !$past(TIMER_LEVEL_I[4]))
    else $error("group B level not inverted");

  // write paths: a setup cycle, then the access cycle in which the register lands
  sequence enable_write_access;
    PSEL_I && !PENABLE_I && PWRITE_I && hit_enable ##1 PSEL_I && PENABLE_I;
  endsequence

  sequence control_write_access;
    PSEL_I && !PENABLE_I && PWRITE_I && hit_control ##1 PSEL_I && PENABLE_I;
  endsequence

  enable_write_a: assert property (enable_write_access ##0 (!trigger && !STANDBY_I)
    |=> enable_read == {2'h3, $past(PWDATA_I[5:0])})
    else $error("master enable write lost or reached reserved bits");

  control_write_a: assert property (control_write_access ##0 !STANDBY_I
    |=> control_read == ($past(PWDATA_I[7:0]) | 8'hec))
    else $error("control write lost or reached reserved bits");

  // zero wait states: ready answers every setup for exactly one cycle
  ready_pulse_a: assert property (setup |=> PREADY_O ##1 !PREADY_O)
    else $error("ready did not stand for exactly the access cycle");

  // an unmapped access answers with an error and no read data
  unmapped_error_a: assert property (setup && unmapped
    |=> PREADY_O && PSLVERR_O && PRDATA_O == 32'h0000_0000)
    else $error("unmapped access did not answer with an error");

  // pins 0 to 2 follow the group A select, pins 3 to 5 the group B select
  function automatic logic in_group_a(input int unsigned pin);
    in_group_a = (pin == out_gate_pkg::PIN_CH3_A) || (pin == out_gate_pkg::PIN_CH4_A)
      || (pin == out_gate_pkg::PIN_CH4_B);
  endfunction : in_group_a

  generate
    for (g = 0; g < 6; g++) begin : g_chk
      pin_gated_a: assert property (
        !state.enable[g] |=> PIN_LEVEL_O[g] == $past(GPIO_LEVEL_I[g])
        && PIN_OE_O[g] == $past(GPIO_OE_I[g]))
        else $error("disabled pin did not follow port logic");
      pin_timer_a: assert property (
        state.enable[g] |=> PIN_OE_O[g] == $past(TIMER_OE_I[g]))
        else $error("enabled pin did not follow channel settings");
      pin_level_a: assert property (
        state.enable[g] && (!combo_mode || (in_group_a(g) ?
        state.level_select_group_a : state.level_select_group_b))
        |=> PIN_LEVEL_O[g] == $past(TIMER_LEVEL_I[g]))
        else $error("enabled pin level inverted without a select");
      pin_invert_a: assert property (
        state.enable[g] && combo_mode && !(in_group_a(g) ?
        state.level_select_group_a : state.level_select_group_b)
        |=> PIN_LEVEL_O[g] == !$past(TIMER_LEVEL_I[g]))
        else $error("enabled pin level not inverted by its select");
    end
  endgenerate

endmodule : timer_output_gate_ch34

/* verilog/out_gate_pkg.sv */
/*
  Shared constants for the channel 3/4 output gate: register offsets,
  field positions, reset values and combination mode codes.
  Assumes a 32-bit APB with one aligned word per register.
*/
package out_gate_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_MASTER_ENABLE = 12'h000;
  localparam logic [11:0] OFS_LEVEL_TRIGGER = 12'h004;

  // pin index order used on every six-bit pin vector
  localparam int unsigned PIN_CH3_A = 0;
  localparam int unsigned PIN_CH4_A = 1;
  localparam int unsigned PIN_CH4_B = 2;
  localparam int unsigned PIN_CH3_B = 3;
  localparam int unsigned PIN_CH4_AUX_A = 4;
  localparam int unsigned PIN_CH4_AUX_B = 5;
  localparam int unsigned NUM_PINS = 6;

  // master enable register layout
  localparam logic [7:0] MASTER_ENABLE_RESET = 8'hff;
  localparam logic [7:0] MASTER_ENABLE_RSVD = 8'hc0;
  localparam logic [5:0] ENABLE_ALL = 6'h3f;
  localparam logic [5:0] ENABLE_NONE = 6'h00;

  // level/trigger control register layout
  localparam logic [7:0] LEVEL_TRIGGER_RESET = 8'hff;
  localparam logic [7:0] LEVEL_TRIGGER_RSVD = 8'hec;
  localparam int unsigned BIT_EXT_TRIGGER_DISABLE = 4;
  localparam int unsigned BIT_LEVEL_GROUP_A = 1;
  localparam int unsigned BIT_LEVEL_GROUP_B = 0;

  // combination mode codes {hi, lo}
  localparam logic [1:0] COMBO_COMPLEMENTARY = 2'h2;
  localparam logic [1:0] COMBO_RESET_SYNC = 2'h3;

  // pins inverted by each level select bit
  localparam logic [5:0] GROUP_A_PINS = 6'h07;
  localparam logic [5:0] GROUP_B_PINS = 6'h38;

endpackage : out_gate_pkg

/* verilog/apb_word_decode.sv */
/*
  Combinational APB decode for a zero-wait-state slave.
  Assumes psel, penable, pwrite and paddr come from the same clock domain.
*/
`timescale 1ns/1ps
module apb_word_decode (
  input wire logic psel_i, // slave selected
  input wire logic penable_i, // access phase
  input wire logic pwrite_i, // write direction
  input wire logic [11:0] paddr_i, // byte address
  output logic setup_o, // setup cycle in progress
  output logic hit_enable_o, // address is the master enable register
  output logic hit_control_o, // address is the level/trigger control register
  output logic unmapped_o // address decodes to nothing
);

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  always_comb begin
    setup_o = psel_i && !penable_i;
    hit_enable_o = 1'b0;
    hit_control_o = 1'b0;
    unmapped_o = 1'b0;
    if (addr_is(paddr_i, out_gate_pkg::OFS_MASTER_ENABLE)) begin
      hit_enable_o = 1'b1;
    end else if (addr_is(paddr_i, out_gate_pkg::OFS_LEVEL_TRIGGER)) begin
      hit_control_o = 1'b1;
    end else begin
      unmapped_o = 1'b1;
    end
  end

endmodule : apb_word_decode

/* verilog/pin_output_mux.sv */
/*
  One pin's output selection: timer waveform with optional inversion when
  the master enable is set, general-purpose port drive otherwise.
  Assumes all inputs are on the system clock; the caller registers the result.
*/
`timescale 1ns/1ps
module pin_output_mux (
  input wire logic enable_i, // master enable for this pin
  input wire logic invert_i, // invert timer level
  input wire logic timer_level_i, // level from channel logic
  input wire logic timer_oe_i, // channel settings make this an output
  input wire logic gpio_level_i, // level from port logic
  input wire logic gpio_oe_i, // port logic drives the pin
  output logic level_o, // selected level
  output logic oe_o // selected output enable
);

  always_comb begin
    if (enable_i) begin
      level_o = timer_level_i ^ invert_i;
      oe_o = timer_oe_i;
    end else begin
      level_o = gpio_level_i;
      oe_o = gpio_oe_i;
    end
  end

endmodule : pin_output_mux

/* tb/pad_load_model.sv */
/*
  Pad and load model for the six waveform pins of channels 3 and 4.
  Assumes the gate hands over a registered level and drive enable per pin.
*/
`timescale 1ns/1ps
module pad_load_model (
  input wire logic [5:0] level_i, // driven levels
  input wire logic [5:0] oe_i, // drive enables
  output logic [5:0] pad_o // level seen on each pad
);
  // each load carries a pull-up, so a released pad reads high and never
  // keeps showing the last driven level
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pad_o[i] = oe_i[i] ? level_i[i] : 1'b1;
    end
  end
endmodule : pad_load_model

/* tb/tb.sv */
/*
  Self-checking bench for the channel 3/4 output gate: APB register tasks,
  pin gating, level inversion, external trigger and standby reload.
  Assumes the zero-wait APB slave and one-cycle pin latency of the design.
*/
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, se;
  logic standby = 1'b0;
  logic cap = 1'b0;
  logic hi = 1'b0;
  logic lo = 1'b0;
  logic [5:0] tlev = 6'h3f;
  logic [5:0] toe = 6'h37;
  logic [5:0] glev = 6'h2a;
  logic [5:0] goe = 6'h15;
  logic [5:0] plev, poe, pad;
  int err_total = 0;
  int checks_done = 0;
  localparam logic [11:0] ME = out_gate_pkg::OFS_MASTER_ENABLE;
  localparam logic [11:0] LT = out_gate_pkg::OFS_LEVEL_TRIGGER;

  always #20 clk = ~clk;

  timer_output_gate_ch34 u_dut (
    .MCLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .STANDBY_I(standby),
    .CAPTURE_A_CH1_I(cap), .COMBINATION_MODE_HI_I(hi), .COMBINATION_MODE_LO_I(lo),
    .TIMER_LEVEL_I(tlev), .TIMER_OE_I(toe), .GPIO_LEVEL_I(glev), .GPIO_OE_I(goe),
    .PIN_LEVEL_O(plev), .PIN_OE_O(poe)
  );

  pad_load_model u_pads (.level_i(plev), .oe_i(poe), .pad_o(pad));

  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one APB transfer; read data and error are taken at the ready edge only
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      err_total++;
      $display("BAD t=%0t no ready", $time);
      end_of_test();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task pulse_cap;
    @(posedge clk);
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
  endtask : pulse_cap

  // pads follow the timer side where enabled, the port side elsewhere
  task pins(input logic [5:0] en, input logic [5:0] inv);
    logic [5:0] el, eo, lv;
    repeat (2) @(posedge clk);
    eo = (en & toe) | (~en & goe);
    for (int i = 0; i < 6; i++) begin
      lv[i] = en[i] ? tlev[i] ^ inv[i] : glev[i];
      el[i] = eo[i] ? lv[i] : 1'b1;
    end
    chk({26'h0, plev}, {26'h0, lv});
    chk({26'h0, pad}, {26'h0, el});
    chk({26'h0, poe}, {26'h0, eo});
  endtask : pins

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, ME, 32'h0);
    chk(rd, 32'h000000ff);
    apb(1'b0, LT, 32'h0);
    chk(rd, 32'h000000ff);
    apb(1'b1, ME, 32'hffffff00);
    apb(1'b0, ME, 32'h0);
    chk(rd, 32'h000000c0);
    apb(1'b1, LT, 32'h0);
    apb(1'b0, LT, 32'h0);
    chk(rd, 32'h000000ec);
    apb(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], se}, 32'h1);
    // normal mode with both level selects low: gating only, no inversion
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ME, 32'h1 << i);
      pins(6'h1 << i, 6'h00);
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      {hi, lo} <= m[1:0];
      apb(1'b1, ME, 32'h3f);
      pins(6'h3f, m[1] ? 6'h3f : 6'h00);
      pulse_cap();
      apb(1'b0, ME, 32'h0);
      chk(rd, m[1] ? 32'h000000c0 : 32'h000000ff);
    end
    apb(1'b1, ME, 32'h3f);
    apb(1'b1, LT, 32'h2);
    pins(6'h3f, 6'h38);
    apb(1'b1, LT, 32'h1);
    pins(6'h3f, 6'h07);
    // capture at the very edge that completes a master enable write
    fork
      apb(1'b1, ME, 32'h3f);
      begin
        repeat (2) @(posedge clk);
        cap <= 1'b1;
        @(posedge clk);
        cap <= 1'b0;
      end
    join
    apb(1'b0, ME, 32'h0);
    chk(rd, 32'h000000c0);
    apb(1'b1, ME, 32'h3f);
    apb(1'b1, LT, 32'h10);
    pulse_cap();
    apb(1'b0, ME, 32'h0);
    chk(rd, 32'h000000ff);
    // standby reload after both registers were cleared
    apb(1'b1, ME, 32'h0);
    apb(1'b1, LT, 32'h0);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    apb(1'b0, ME, 32'h0);
    chk(rd, 32'h000000ff);
    apb(1'b0, LT, 32'h0);
    chk(rd, 32'h000000ff);
    end_of_test();
  end
endmodule : tb
